//--- prp_pulse_input.v
`timescale 1ns/100ps
`default_nettype none
`include "prp_defs.vh"

// Behaviour
// - The pulse form select picks sign plus pulse, forward/reverse pair, or quadrature x1, x2, x4.
// - In sign plus pulse form each pulse goes forward with direction high and reverse with it low.
// - Every decoded edge adds exactly one increment to the commanded position.
// - Multiplication by two or four exists only in quadrature form; other forms count once a pulse.
// - Decoded increments are scaled by an electronic gear weight before reaching the command.
// - While the clear input is low the position error counter is held at zero.
// - While the clear input is low the position loop is suspended.
// - A select chooses whether residual error is cleared at servo off (0) or kept (1).
// - With clearing at servo off disabled, the host clears the pulses before servo on again.
// - The command passes a first-order filter with a time constant in 0.1 ms steps, 0 bypasses.
module prp_pulse_input #(
  parameter SMOOTH_UNIT_CYCLES = `PRP_SMOOTH_UNIT_CYCLES
) (
  input wire clk_i,
  input wire reset_n_i,
  input wire ce_i,
  input wire step_pulse_in_i,
  input wire step_dir_in_i,
  input wire error_counter_clear_n_i,
  input wire servo_on_i,
  input wire [2:0] pulse_form_select_i,
  input wire [1:0] input_polarity_select_i,
  input wire clear_on_servo_off_select_i,
  input wire [14:0] reference_smoothing_constant_i,
  input wire [7:0] gear_weight_i,
  input wire feedback_step_i,
  input wire feedback_forward_i,
  output wire step_strobe_o,
  output wire step_forward_o,
  output wire signed [31:0] position_command_o,
  output wire signed [31:0] smoothed_command_o,
  output wire signed [31:0] error_count_o,
  output wire position_loop_enable_o
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // bit 0 pulse, bit 1 direction, bit 2 clear_n; stage one feeds only stage two
  reg [2:0] meta_r;
  reg [2:0] sync_r;

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_r <= 3'h4;
      sync_r <= 3'h4;
    end else if (ce_i) begin
      meta_r <= {error_counter_clear_n_i, step_dir_in_i, step_pulse_in_i};
      sync_r <= meta_r;
    end
  end

  // ----------------------------------------
  // polarity
  // ----------------------------------------
  wire pulse_w;
  wire dir_w;
  wire clear_w;

  assign pulse_w = sync_r[0] ^ input_polarity_select_i[`PRP_POL_PULSE_BIT];
  assign dir_w = sync_r[1] ^ input_polarity_select_i[`PRP_POL_DIR_BIT];
  assign clear_w = ~sync_r[2];

  // ----------------------------------------
  // edge history
  // ----------------------------------------
  reg pulse_q_r;
  reg dir_q_r;
  reg primed_r;

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pulse_q_r <= 1'b0;
      dir_q_r <= 1'b0;
      primed_r <= 1'b0;
    end else if (ce_i) begin
      pulse_q_r <= pulse_w;
      dir_q_r <= dir_w;
      primed_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // decoder
  // ----------------------------------------
  // history is not valid on the first enabled cycle, so no edge is seen then
  wire pulse_rise_w;
  wire dir_rise_w;
  wire pulse_chg_w;
  wire dir_chg_w;
  wire quad_fwd_w;
  reg dec_step_nxt;
  reg dec_fwd_nxt;

  assign pulse_rise_w = primed_r & pulse_w & ~pulse_q_r;
  assign dir_rise_w = primed_r & dir_w & ~dir_q_r;
  assign pulse_chg_w = primed_r & (pulse_w ^ pulse_q_r);
  assign dir_chg_w = primed_r & (dir_w ^ dir_q_r);
  // a leading b: the new a differs from the old b
  assign quad_fwd_w = pulse_w ^ dir_q_r;

  always @* begin
    dec_step_nxt = 1'b0;
    dec_fwd_nxt = 1'b0;
    case (pulse_form_select_i)
      `PRP_FORM_SIGN_PULSE: begin
        dec_step_nxt = pulse_rise_w;
        dec_fwd_nxt = dir_w;
      end
      `PRP_FORM_FWD_REV: begin
        // simultaneous edges on both lines cancel
        dec_step_nxt = pulse_rise_w ^ dir_rise_w;
        dec_fwd_nxt = pulse_rise_w;
      end
      `PRP_FORM_QUAD_X1: begin
        dec_step_nxt = pulse_rise_w & ~dir_chg_w;
        dec_fwd_nxt = quad_fwd_w;
      end
      `PRP_FORM_QUAD_X2: begin
        dec_step_nxt = pulse_chg_w & ~dir_chg_w;
        dec_fwd_nxt = quad_fwd_w;
      end
      `PRP_FORM_QUAD_X4: begin
        dec_step_nxt = pulse_chg_w ^ dir_chg_w;
        dec_fwd_nxt = quad_fwd_w;
      end
      default: begin
        dec_step_nxt = 1'b0;
        dec_fwd_nxt = 1'b0;
      end
    endcase
  end

  reg step_strobe_r;
  reg step_forward_r;

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      step_strobe_r <= 1'b0;
      step_forward_r <= 1'b0;
    end else if (ce_i) begin
      step_strobe_r <= dec_step_nxt;
      step_forward_r <= dec_fwd_nxt;
    end
  end

  assign step_strobe_o = step_strobe_r;
  assign step_forward_o = step_forward_r;

  // ----------------------------------------
  // commanded position
  // ----------------------------------------
  // gear weight 0 would freeze the command, so it counts as 1
  wire [7:0] weight_w;
  wire signed [31:0] weight_ext_w;
  reg signed [31:0] cmd_r;

  assign weight_w = (gear_weight_i == 8'h00) ? 8'h01 : gear_weight_i;
  assign weight_ext_w = {24'h0, weight_w};

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmd_r <= 32'sh0;
    end else if (ce_i && step_strobe_r) begin
      if (step_forward_r) begin
        cmd_r <= cmd_r + weight_ext_w;
      end else begin
        cmd_r <= cmd_r - weight_ext_w;
      end
    end
  end

  assign position_command_o = cmd_r;

  // ----------------------------------------
  // smoothing tick
  // ----------------------------------------
  reg [31:0] tick_cnt_r;
  reg tick_r;

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tick_cnt_r <= 32'h0;
      tick_r <= 1'b0;
    end else if (ce_i) begin
      if (tick_cnt_r >= SMOOTH_UNIT_CYCLES - 1) begin
        tick_cnt_r <= 32'h0;
        tick_r <= 1'b1;
      end else begin
        tick_cnt_r <= tick_cnt_r + 32'h1;
        tick_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // clear conditions
  // ----------------------------------------
  wire soff_clear_w;
  wire err_clear_w;

  assign soff_clear_w = ~servo_on_i & (clear_on_servo_off_select_i == `PRP_SOFF_CLEAR);
  assign err_clear_w = clear_w | soff_clear_w;

  // ----------------------------------------
  // smoother
  // ----------------------------------------
  // at automatic servo-off clear the filter snaps to the command so no
  // residual lag reappears as error at servo on
  wire signed [31:0] smooth_w;

  prp_smoother u_smoother (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .tick_i(tick_r),
    .load_i(soff_clear_w),
    .time_const_i(reference_smoothing_constant_i),
    .target_i(cmd_r),
    .smooth_o(smooth_w)
  );

  assign smoothed_command_o = smooth_w;

  // ----------------------------------------
  // error counter
  // ----------------------------------------
  // with keep selected the host must pulse clear before servo on
  reg signed [31:0] smooth_q_r;
  reg signed [31:0] err_r;
  wire signed [31:0] cmd_delta_w;
  wire signed [31:0] fb_delta_w;

  assign cmd_delta_w = smooth_w - smooth_q_r;
  assign fb_delta_w = !feedback_step_i ? 32'sh0 :
                      (feedback_forward_i ? 32'sh1 : -32'sh1);

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      smooth_q_r <= 32'sh0;
      err_r <= 32'sh0;
    end else if (ce_i) begin
      smooth_q_r <= smooth_w;
      if (err_clear_w) begin
        err_r <= 32'sh0;
      end else begin
        err_r <= err_r + cmd_delta_w - fb_delta_w;
      end
    end
  end

  assign error_count_o = err_r;

  // ----------------------------------------
  // loop enable
  // ----------------------------------------
  reg loop_en_r;

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      loop_en_r <= 1'b0;
    end else if (ce_i) begin
      loop_en_r <= servo_on_i & ~clear_w;
    end
  end

  assign position_loop_enable_o = loop_en_r;

endmodule
`default_nettype wire

//--- prp_defs.vh
`ifndef PRP_DEFS_VH
`define PRP_DEFS_VH

// ----------------------------------------
// pulse form codes
// ----------------------------------------
`define PRP_FORM_SIGN_PULSE 3'h0
`define PRP_FORM_FWD_REV 3'h1
`define PRP_FORM_QUAD_X1 3'h2
`define PRP_FORM_QUAD_X2 3'h3
`define PRP_FORM_QUAD_X4 3'h4
`define PRP_FORM_RESET 3'h0

// ----------------------------------------
// polarity field positions and reset
// ----------------------------------------
`define PRP_POL_DIR_BIT 0
`define PRP_POL_PULSE_BIT 1
`define PRP_POL_RESET 2'h0

// ----------------------------------------
// servo-off clear select
// ----------------------------------------
`define PRP_SOFF_CLEAR 1'h0
`define PRP_SOFF_KEEP 1'h1

// ----------------------------------------
// smoothing timing
// ----------------------------------------
`define PRP_SMOOTH_RESET 15'h0000
`define PRP_CLK_PERIOD_NS 5
`define PRP_SMOOTH_UNIT_NS 100000
`define PRP_SMOOTH_UNIT_CYCLES (`PRP_SMOOTH_UNIT_NS / `PRP_CLK_PERIOD_NS)

// ----------------------------------------
// widths
// ----------------------------------------
`define PRP_POS_W 32
`define PRP_ACC_W 48

`endif

//--- prp_smoother.v
`timescale 1ns/100ps
`default_nettype none
`include "prp_defs.vh"

module prp_smoother (
  input wire clk_i,
  input wire reset_n_i,
  input wire ce_i,
  input wire tick_i,
  input wire load_i,
  input wire [14:0] time_const_i,
  input wire signed [31:0] target_i,
  output wire signed [31:0] smooth_o
);

  // ----------------------------------------
  // first-order lag, one count per cycle
  // ----------------------------------------
  // the output walks one count per clock, which caps the slew at the clock
  // rate but avoids a divider by an arbitrary time constant
  reg signed [31:0] out_r;
  reg signed [31:0] out_nxt;
  reg signed [47:0] acc_r;
  reg signed [47:0] acc_nxt;
  wire signed [31:0] diff_w;
  wire signed [47:0] tc_w;

  assign diff_w = target_i - out_r;
  assign tc_w = {33'h0, time_const_i};
  assign smooth_o = out_r;

  always @* begin
    acc_nxt = acc_r;
    out_nxt = out_r;
    if (load_i || time_const_i == 15'h0000) begin
      out_nxt = target_i;
      acc_nxt = 48'h0;
    end else begin
      if (tick_i) begin
        acc_nxt = acc_r + {{16{diff_w[31]}}, diff_w};
      end
      if (acc_nxt >= tc_w) begin
        acc_nxt = acc_nxt - tc_w;
        out_nxt = out_r + 32'sh1;
      end else if (acc_nxt <= -tc_w) begin
        acc_nxt = acc_nxt + tc_w;
        out_nxt = out_r - 32'sh1;
      end
    end
  end

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      out_r <= 32'sh0;
      acc_r <= 48'sh0;
    end else if (ce_i) begin
      out_r <= out_nxt;
      acc_r <= acc_nxt;
    end
  end

endmodule
`default_nettype wire

//--- prp_pulse_input_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------
// port checker
// ----------------
module prp_pulse_input_chk (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic step_dir_in_i,
  input wire logic error_counter_clear_n_i,
  input wire logic servo_on_i,
  input wire logic [2:0] pulse_form_select_i,
  input wire logic [1:0] input_polarity_select_i,
  input wire logic clear_on_servo_off_select_i,
  input wire logic [14:0] reference_smoothing_constant_i,
  input wire logic [7:0] gear_weight_i,
  input wire logic step_strobe_o,
  input wire logic step_forward_o,
  input wire logic signed [31:0] position_command_o,
  input wire logic signed [31:0] smoothed_command_o,
  input wire logic signed [31:0] error_count_o,
  input wire logic position_loop_enable_o
);
  logic signed [31:0] w;
  // zero weight counts as one
  assign w = (gear_weight_i == 8'h0) ? 32'sh1 : {24'h0, gear_weight_i};
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  strobe_one_cycle_a:
    assert property (step_strobe_o |=> !step_strobe_o) else $error("strobe too long");
  command_step_a:
    assert property (step_strobe_o |=> position_command_o - $past(position_command_o)
      == ($past(step_forward_o) ? $past(w) : -$past(w))) else $error("bad command step");
  command_hold_a:
    assert property (!step_strobe_o |=> $stable(position_command_o))
      else $error("command moved without strobe");
  clear_zero_a:
    assert property ((!error_counter_clear_n_i) [*5] |-> error_count_o == 32'sh0)
      else $error("error count not zero in clear");
  clear_loop_a:
    assert property ((!error_counter_clear_n_i) [*5] |-> !position_loop_enable_o)
      else $error("loop on during clear");
  servo_loop_a:
    assert property ((!servo_on_i) [*2] |-> !position_loop_enable_o)
      else $error("loop on with servo off");
  bad_form_a:
    assert property ((pulse_form_select_i > 3'h4) [*6] |-> !step_strobe_o)
      else $error("strobe in unused form");
  bypass_a:
    assert property ((reference_smoothing_constant_i == 15'h0) [*8]
      |-> smoothed_command_o == $past(position_command_o)) else $error("bypass lags");
  sign_dir_a:
    assert property (step_strobe_o && pulse_form_select_i == 3'h0
      && input_polarity_select_i == 2'h0 |-> step_forward_o == $past(step_dir_in_i, 3))
      else $error("direction differs from sign line");
  servo_off_clear_a:
    assert property ($fell(servo_on_i) && !clear_on_servo_off_select_i
      |-> ##[1:6] error_count_o == 32'sh0) else $error("no clear at servo off");
  quad_x4_c: cover property (step_strobe_o && pulse_form_select_i == 3'h4);
  clear_c: cover property ((!error_counter_clear_n_i) [*5]);
  servo_off_c: cover property ($fell(servo_on_i));
endmodule
bind prp_pulse_input prp_pulse_input_chk chk_u (.*);
`default_nettype wire

//--- prp_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------
// host pulse source
// ----------------
module prp_host_model (
  input wire logic clk_i,
  output logic pulse_o,
  output logic dir_o
);
  logic [1:0] pol = 2'h0;
  int hw = 2;
  initial {pulse_o, dir_o} = 2'h0;
  // hold of 2 or more keeps every level visible
  task put(input logic [1:0] ab);
    @(posedge clk_i);
    {pulse_o, dir_o} <= ab ^ pol;
    repeat (hw - 1) @(posedge clk_i);
  endtask
  task step(input logic [2:0] f, input logic fw);
    if (f == 3'h0) begin
      put({1'b0, fw});
      put({1'b1, fw});
      put({1'b0, fw});
    end else if (f == 3'h1) begin
      put(fw ? 2'h2 : 2'h1);
      put(2'h0);
    end else if (fw) begin
      put(2'h2);
      put(2'h3);
      put(2'h1);
      put(2'h0);
    end else begin
      put(2'h1);
      put(2'h3);
      put(2'h2);
      put(2'h0);
    end
  endtask
endmodule
`default_nettype wire

//--- prp_pulse_input_test.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------
// bench
// ----------------
module prp_pulse_input_test;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic feedback_step_i = 1'b0;
  logic feedback_forward_i = 1'b0;
  logic error_counter_clear_n_i = 1'b1;
  logic servo_on_i = 1'b1;
  logic clear_on_servo_off_select_i = 1'b1;
  logic quiet = 1'b1;
  logic [2:0] pulse_form_select_i = 3'h0;
  logic [1:0] input_polarity_select_i = 2'h0;
  logic [14:0] reference_smoothing_constant_i = 15'h0;
  logic [7:0] gear_weight_i = 8'h0;
  wire logic step_pulse_in_i, step_dir_in_i, step_strobe_o, step_forward_o;
  wire logic position_loop_enable_o;
  wire logic signed [31:0] position_command_o, smoothed_command_o, error_count_o;
  int fails = 0;
  int n_tests = 0;
  int exp_err = 0;
  int exp_cmd = 0;
  logic q[$];
  prp_pulse_input #(.SMOOTH_UNIT_CYCLES(4)) dut_u (.*);
  prp_host_model host_u (.clk_i(clk_i), .pulse_o(step_pulse_in_i), .dir_o(step_dir_in_i));
  initial forever #2.5 clk_i = ~clk_i;
  task cmp(input logic [31:0] a, input logic [31:0] e);
    n_tests++;
    if (a !== e) begin
      fails++;
      $display("[ERR] %0t got %0h expected %0h", $time, a, e);
    end
  endtask
  task results;
    if (fails == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // strobes from config changes are stray, so quiet masks them
  // sampled mid-cycle, where the one-cycle strobe stands settled
  always @(negedge clk_i) begin
    if (step_strobe_o && !quiet) begin
      if (q.size() == 0) cmp(1'b1, 1'b0);
      else cmp(step_forward_o, q.pop_front());
    end
  end
  task cfg(input logic [2:0] f, input logic [1:0] p, input logic [14:0] t);
    quiet = 1'b1;
    @(posedge clk_i);
    pulse_form_select_i <= f;
    input_polarity_select_i <= p;
    reference_smoothing_constant_i <= t;
    gear_weight_i <= (f == 3'h1) ? 8'h0 : 8'($urandom);
    host_u.pol = p;
    host_u.put(2'h0);
    repeat (8) @(posedge clk_i);
    error_counter_clear_n_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    error_counter_clear_n_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    cmp(error_count_o, 32'h0);
    cmp(position_loop_enable_o, 1'b1);
    exp_err = 0;
    // baseline only: stray strobes of the config change moved the command
    exp_cmd = position_command_o;
    quiet = 1'b0;
  endtask
  task step(input logic fw);
    int c;
    int d;
    c = (pulse_form_select_i == 3'h3) ? 2 : (pulse_form_select_i == 3'h4) ? 4 : 1;
    if (pulse_form_select_i > 3'h4) c = 0;
    repeat (c) q.push_back(fw);
    d = c * (gear_weight_i == 8'h0 ? 1 : int'(gear_weight_i)) * (fw ? 1 : -1);
    exp_err += d;
    exp_cmd += d;
    host_u.hw = 2 + $urandom % 4;
    host_u.step(pulse_form_select_i, fw);
  endtask
  task settle;
    for (int i = 0; i < 50 && q.size() > 0; i++) @(posedge clk_i);
    repeat (4) @(posedge clk_i);
    cmp(q.size(), 0);
    cmp(error_count_o, exp_err);
    cmp(position_command_o, exp_cmd);
  endtask
  initial begin
    void'($urandom(84758));
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    for (int f = 0; f < 8; f++) begin
      for (int p = 0; p < (f == 0 ? 4 : 1); p++) begin
        cfg(3'(f), 2'(p), 15'h0);
        repeat (6) step(1'($urandom));
        settle;
      end
    end
    cfg(3'h0, 2'h0, 15'h3);
    step(1'b1);
    for (int i = 0; i < 20 && smoothed_command_o === position_command_o; i++) @(posedge clk_i);
    cmp(smoothed_command_o !== position_command_o, 1'b1);
    for (int i = 0; i < 3000 && smoothed_command_o !== position_command_o; i++)
      @(posedge clk_i);
    cmp(smoothed_command_o, position_command_o);
    settle;
    cfg(3'h0, 2'h0, 15'h0);
    step(1'b0);
    settle;
    servo_on_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    cmp(error_count_o, exp_err);
    cmp(position_loop_enable_o, 1'b0);
    error_counter_clear_n_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    error_counter_clear_n_i <= 1'b1;
    servo_on_i <= 1'b1;
    exp_err = 0;
    step(1'b1);
    // three feedback counts forward take three off the error
    feedback_forward_i <= 1'b1;
    repeat (3) begin
      @(posedge clk_i);
      feedback_step_i <= 1'b1;
    end
    @(posedge clk_i);
    feedback_step_i <= 1'b0;
    exp_err -= 3;
    settle;
    clear_on_servo_off_select_i <= 1'b0;
    servo_on_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    cmp(error_count_o, 32'h0);
    results;
  end
  initial begin
    #200000;
    fails++;
    results;
  end
endmodule
`default_nettype wire
